// ==== core/acc_ctrl.sv ====
// Converter sequencing block with AXI4-Lite registers.
// Assumes an analog core that returns a sample word; sleep status from the core.
`timescale 1ns/1ps
module acc_ctrl
    import acc_pkg::*;
#(
    parameter int RC_DIV = 64    // Internal oscillator ratio stand-in
)(
    input  wire logic        CLOCK_IN,
    input  wire logic        ARST_N_IN,
    input  wire logic [7:0]  S_AXI_AWADDR_IN,
    input  wire logic        S_AXI_AWVALID_IN,
    output logic             S_AXI_AWREADY_OUT,
    input  wire logic [31:0] S_AXI_WDATA_IN,
    input  wire logic [3:0]  S_AXI_WSTRB_IN,
    input  wire logic        S_AXI_WVALID_IN,
    output logic             S_AXI_WREADY_OUT,
    output logic [1:0]       S_AXI_BRESP_OUT,
    output logic             S_AXI_BVALID_OUT,
    input  wire logic        S_AXI_BREADY_IN,
    input  wire logic [7:0]  S_AXI_ARADDR_IN,
    input  wire logic        S_AXI_ARVALID_IN,
    output logic             S_AXI_ARREADY_OUT,
    output logic [31:0]      S_AXI_RDATA_OUT,
    output logic [1:0]       S_AXI_RRESP_OUT,
    output logic             S_AXI_RVALID_OUT,
    input  wire logic        S_AXI_RREADY_IN,
    input  wire logic        SLEEP_IN,          // Core asleep, asynchronous
    input  wire logic [9:0]  SAMPLE_IN,         // Analog core result, asynchronous
    output logic             CONVERTER_POWER_OUT, // Analog core powered
    output logic [4:0]       CHANNEL_OUT,       // Mux selection
    output logic             CHANNEL_VALID_OUT, // Code is implemented
    output logic             ACQUIRE_OUT,       // Sample and hold tracking
    output logic             CONV_DONE_FLAG_OUT,
    output logic             WAKE_OUT           // One-cycle wake pulse
);
    // State of the block apart from the pin synchronisers and the divider
    typedef struct packed {
        logic        awr, wr, bv, arr, rv;
        logic [7:0]  awa;
        logic [31:0] wd;
        logic [3:0]  ws;
        logic        bok;
        logic [31:0] rd;
        logic        rok;
        logic        en;          // converter_enable
        logic        go;          // Start/status
        logic [4:0]  chs;
        logic [2:0]  cks;
        logic [9:0]  res;
        logic        flag;        // conv_done_flag
        logic        irqen;       // conv_irq_enable
        acc_state_t  st;
        logic [3:0]  tads;
        logic [7:0]  dly;
        logic        pwr, acq, wake, chv;
    } acc_st_t;
    acc_st_t s_q, s_d;

    // Two-flop pin synchronisers
    logic [1:0]  slp_sync_q;
    logic [9:0]  smp_a_q, smp_b_q;
    logic        sleep_s;
    assign sleep_s = slp_sync_q[1];

    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
        if (!ARST_N_IN)
        begin
            slp_sync_q <= 2'h0;
            smp_a_q    <= 10'h000;
            smp_b_q    <= 10'h000;
        end
        else
        begin
            slp_sync_q <= {slp_sync_q[0], SLEEP_IN};
            smp_a_q    <= SAMPLE_IN;
            smp_b_q    <= smp_a_q;
        end

    acc_tad_if tad ();
    acc_tad_div #(.RC_DIV(RC_DIV)) u_div (
        .clk_in    (CLOCK_IN),
        .arst_n_in (ARST_N_IN),
        .tad       (tad)
    );
    assign tad.sel = s_q.cks;
    // Divider idles one cycle on abort entry so both waiting periods are whole
    assign tad.run = (s_q.st == ACC_CONV) || (s_q.st == ACC_ABORT && s_q.tads != 4'hF);

    logic rc_sel;                 // Internal oscillator clock chosen
    assign rc_sel = (s_q.cks[1:0] == 2'h3);

    // Bus, registers and sequencer
    always_comb
    begin
        logic        wr_go, wr_do, rd_do, sw_start, sw_stop, sw_flagclr, done;
        logic [7:0]  b0;
        s_d = s_q;
        wr_go = 1'b0;
        wr_do = 1'b0;
        rd_do = 1'b0;
        sw_start = 1'b0;
        sw_stop = 1'b0;
        sw_flagclr = 1'b0;
        done = 1'b0;
        b0 = s_q.wd[7:0];
        s_d.wake = 1'b0;
        // Capture address and data separately, either order
        if (S_AXI_AWVALID_IN && s_q.awr)
        begin
            s_d.awa = S_AXI_AWADDR_IN;
            s_d.awr = 1'b0;
        end
        if (S_AXI_WVALID_IN && s_q.wr)
        begin
            s_d.wd = S_AXI_WDATA_IN;
            s_d.ws = S_AXI_WSTRB_IN;
            s_d.wr = 1'b0;
        end
        wr_do = !s_q.awr && !s_q.wr && !s_q.bv;
        if (wr_do)
        begin
            s_d.bv  = 1'b1;
            s_d.bok = 1'b1;
            if (!s_q.ws[0])
                wr_go = 1'b0;     // Low lane absent: nothing to store
            else if (s_q.awa == ACC_OFS_CTRL)
            begin
                wr_go = 1'b1;
                s_d.en  = b0[ACC_BIT_ENABLE];
                s_d.chs = b0[ACC_CHS_LSB +: 5];
                sw_start = b0[ACC_BIT_START] && !s_q.go && s_q.en;
                sw_stop  = !b0[ACC_BIT_START] && s_q.go;
            end
            else if (s_q.awa == ACC_OFS_CLKSEL)
                s_d.cks = b0[ACC_CKS_LSB +: 3];
            else if (s_q.awa == ACC_OFS_IRQ)
            begin
                sw_flagclr = b0[ACC_BIT_FLAG];          // write one clears
                s_d.irqen  = b0[ACC_BIT_IRQEN];
            end
            else if (s_q.awa == ACC_OFS_RESH || s_q.awa == ACC_OFS_RESL)
                wr_go = 1'b0;     // Read-only, write ignored
            else
                s_d.bok = 1'b0;   // Unmapped
        end
        if (s_q.bv && S_AXI_BREADY_IN)
        begin
            s_d.bv  = 1'b0;
            s_d.awr = 1'b1;
            s_d.wr  = 1'b1;
        end
        // Read channel
        rd_do = S_AXI_ARVALID_IN && s_q.arr;
        if (rd_do)
        begin
            s_d.arr = 1'b0;
            s_d.rv  = 1'b1;
            s_d.rok = 1'b1;
            s_d.rd  = 32'h0000_0000;
            if (S_AXI_ARADDR_IN == ACC_OFS_CTRL)
                s_d.rd[7:0] = {1'b0, s_q.chs, s_q.go, s_q.en};
            else if (S_AXI_ARADDR_IN == ACC_OFS_CLKSEL)
                s_d.rd[7:0] = {1'b0, s_q.cks, 4'h0};
            else if (S_AXI_ARADDR_IN == ACC_OFS_RESH)
                s_d.rd[7:0] = {6'h00, s_q.res[9:8]};
            else if (S_AXI_ARADDR_IN == ACC_OFS_RESL)
                s_d.rd[7:0] = s_q.res[7:0];
            else if (S_AXI_ARADDR_IN == ACC_OFS_IRQ)
                s_d.rd[7:0] = {6'h00, s_q.irqen, s_q.flag};
            else
                s_d.rok = 1'b0;
        end
        if (s_q.rv && S_AXI_RREADY_IN)
        begin
            s_d.rv  = 1'b0;
            s_d.arr = 1'b1;
        end
        // Sequencer
        case (s_q.st)
            ACC_IDLE:
            begin
                if (sw_start)
                begin
                    s_d.go   = 1'b1;
                    s_d.acq  = 1'b0;
                    s_d.dly  = rc_sel ? ACC_INSTR_CYC : 8'h00;
                    s_d.st   = rc_sel ? ACC_DELAY : ACC_CONV;
                    s_d.tads = 4'h0;
                end
            end
            ACC_DELAY:
            begin
                if (s_q.dly <= 8'h01)
                    s_d.st = ACC_CONV;
                else
                    s_d.dly = s_q.dly - 8'h01;
            end
            ACC_CONV:
            begin
                if (tad.tick)
                    s_d.tads = s_q.tads + 4'h1;
                if (tad.tick && s_q.tads == ACC_CONV_TADS - 4'h1)
                    done = 1'b1;
            end
            ACC_ABORT:
            begin
                if (s_q.tads == 4'hF)
                    s_d.tads = 4'h0;                     // Divider restarts from zero
                else if (tad.tick)
                    s_d.tads = s_q.tads + 4'h1;
                if (tad.tick && s_q.tads == ACC_ABORT_TADS - 4'h1)
                begin
                    s_d.st  = ACC_IDLE;
                    s_d.acq = s_q.en && s_q.pwr;
                end
            end
            ACC_OFF:
            begin
                if (!sleep_s)
                begin
                    s_d.st  = ACC_IDLE;
                    s_d.pwr = s_q.en;
                    s_d.acq = s_q.en;
                end
            end
            default: s_d.st = ACC_IDLE;
        endcase
        // Abort by software
        if ((s_q.st == ACC_CONV || s_q.st == ACC_DELAY) && sw_stop)
        begin
            s_d.go = 1'b0;                               // result kept
            s_d.st = ACC_ABORT;
            s_d.tads = 4'hF;                             // Marks the divider restart cycle
            done = 1'b0;
        end
        // Sleep with a system-derived clock aborts
        if (sleep_s && !rc_sel && s_q.st != ACC_OFF)
        begin
            s_d.go  = 1'b0;
            s_d.st  = ACC_OFF;
            s_d.pwr = 1'b0;
            s_d.acq = 1'b0;
            done    = 1'b0;
        end
        if (done)
        begin
            s_d.go   = 1'b0;
            s_d.res  = smp_b_q;
            s_d.st   = ACC_IDLE;
            s_d.acq  = 1'b1;
            s_d.wake = sleep_s && s_q.irqen;
            if (sleep_s && !s_q.irqen && rc_sel)
            begin
                s_d.st  = ACC_OFF;
                s_d.pwr = 1'b0;
                s_d.acq = 1'b0;
            end
        end
        // Set beats clear on the same cycle
        if (sw_flagclr)
            s_d.flag = 1'b0;
        if (done)
            s_d.flag = 1'b1;
        // Disable stops everything
        if (!s_d.en)
        begin
            s_d.go  = 1'b0;
            s_d.pwr = 1'b0;
            s_d.acq = 1'b0;
            s_d.st  = ACC_IDLE;
        end
        else if (!s_q.en)
        begin
            s_d.pwr = !sleep_s || rc_sel;
            s_d.acq = s_d.pwr;
        end
        if (wr_go && s_d.en && s_q.st == ACC_IDLE && !sw_start)
            s_d.go = 1'b0;
        // Channel decode
        s_d.chv = (s_d.chs <= 5'h0C) || (s_d.chs[4:3] == 2'h2);
    end

    // State register; reset returns all registers
    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
        if (!ARST_N_IN)
        begin
            s_q     <= '0;
            s_q.awr <= 1'b1;
            s_q.wr  <= 1'b1;
            s_q.arr <= 1'b1;
            s_q.chv <= 1'b1;
        end
        else
            s_q <= s_d;

    assign S_AXI_AWREADY_OUT   = s_q.awr;
    assign S_AXI_WREADY_OUT    = s_q.wr;
    assign S_AXI_BVALID_OUT    = s_q.bv;
    assign S_AXI_BRESP_OUT     = s_q.bok ? 2'h0 : 2'h2;
    assign S_AXI_ARREADY_OUT   = s_q.arr;
    assign S_AXI_RVALID_OUT    = s_q.rv;
    assign S_AXI_RDATA_OUT     = s_q.rd;
    assign S_AXI_RRESP_OUT     = s_q.rok ? 2'h0 : 2'h2;
    assign CONVERTER_POWER_OUT = s_q.pwr;
    assign CHANNEL_OUT         = s_q.chs;
    assign CHANNEL_VALID_OUT   = s_q.chv;
    assign ACQUIRE_OUT         = s_q.acq;
    assign CONV_DONE_FLAG_OUT  = s_q.flag;
    assign WAKE_OUT            = s_q.wake;

    // Software flag-clear write being applied this cycle
    logic wr_flag_clear_seen;
    assign wr_flag_clear_seen = !s_q.awr && !s_q.wr && !s_q.bv && s_q.awa == ACC_OFS_IRQ && s_q.wd[0] && s_q.ws[0];

    // Checks; disabling mid conversion is no completion, hence the enable term
    chk_done_sets_flag: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
        ($fell(s_q.go) && s_q.en && s_q.st == ACC_IDLE && $past(s_q.st) == ACC_CONV) |-> s_q.flag)
        else $error("flag not set on completion");
    chk_flag_no_hw_clear: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
        $fell(s_q.flag) |-> $past(wr_flag_clear_seen))
        else $error("flag cleared without software");
    chk_abort_keeps_res: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
        (s_q.st == ACC_ABORT) |-> $stable(s_q.res))
        else $error("result changed during abort");
    chk_abort_two_tads: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
        (s_q.st == ACC_ABORT && tad.tick && s_q.tads == 4'h1 && s_q.en && !sleep_s) |=> (s_q.st == ACC_IDLE))
        else $error("abort delay wrong");
    chk_start_gated: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
        !s_q.en |-> !s_q.go)
        else $error("busy while disabled");
    chk_hi_zero: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
        (s_q.rv && s_q.rok && $past(S_AXI_ARADDR_IN) == ACC_OFS_RESH && $rose(s_q.rv)) |-> s_q.rd[31:2] == 30'h0)
        else $error("high result upper bits set");
    chk_sleep_abort: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
        (sleep_s && !rc_sel && s_q.st == ACC_CONV) |=> (!s_q.go && !s_q.pwr))
        else $error("sleep did not abort");
    chk_conv_eleven: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
        (s_q.st == ACC_CONV) |-> s_q.tads <= ACC_CONV_TADS)
        else $error("conversion overran");
    chk_busy_go: assert property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN)
        (s_q.st == ACC_CONV) |-> s_q.go)
        else $error("start bit low while busy");
    cov_complete: cover property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN) $rose(s_q.flag));
    cov_abort: cover property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN) s_q.st == ACC_ABORT);
    cov_wake: cover property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN) s_q.wake);
    cov_off: cover property (@(posedge CLOCK_IN) disable iff (!ARST_N_IN) s_q.st == ACC_OFF);
endmodule // acc_ctrl

// ==== core/acc_pkg.sv ====
// Shared constants and types for the converter sequencing block.
// Assumes a single 100 MHz clock domain and an AXI4-Lite register port.
// What this block does
// - Flag set at every conversion end
// - Only software clears the flag
// - Enabled completion wakes the sleeping device
// - Only internal-oscillator clock runs during sleep
// - Result is right justified only
// - Enable bit on; start bit begins conversion
// - Completion clears start, sets flag, loads result
// - Clearing start aborts; result kept
// - Two clock periods, then acquisition restarts
// - Reset clears registers, stops conversion
// - Internal clock delays start one instruction
// - Sleep, internal clock, no irq: power down after completion
// - Sleep with other clocks aborts, powers down
// - Channel codes decoded; others unimplemented
// - Start bit reads one while busy
// - Enable zero disables the converter
// - Clock select field decoded to dividers
// - Unimplemented control bits read zero
// - Conversion takes eleven clock periods
// - High result holds bits nine and eight
package acc_pkg;
    // Register byte offsets
    localparam logic [7:0] ACC_OFS_CTRL   = 8'h00;
    localparam logic [7:0] ACC_OFS_CLKSEL = 8'h04;
    localparam logic [7:0] ACC_OFS_RESH   = 8'h08;
    localparam logic [7:0] ACC_OFS_RESL   = 8'h0C;
    localparam logic [7:0] ACC_OFS_IRQ    = 8'h10;
    // Field positions
    localparam int ACC_BIT_ENABLE = 0;
    localparam int ACC_BIT_START  = 1;
    localparam int ACC_CHS_LSB    = 2;
    localparam int ACC_CKS_LSB    = 4;
    localparam int ACC_BIT_FLAG   = 0;
    localparam int ACC_BIT_IRQEN  = 1;
    // Reset values
    localparam logic [7:0] ACC_RST_CTRL   = 8'h00;
    localparam logic [7:0] ACC_RST_CLKSEL = 8'h00;
    // Timing counts in conversion-clock periods
    localparam logic [3:0] ACC_CONV_TADS  = 4'hB;
    localparam logic [3:0] ACC_ABORT_TADS = 4'h2;
    // Instruction cycle taken as four system clocks
    localparam int ACC_INSTR_NS   = 40;
    localparam int ACC_CLK_NS     = 10;
    localparam logic [7:0] ACC_INSTR_CYC = 8'(ACC_INSTR_NS / ACC_CLK_NS);
    // Sequencer states, Gray in the order listed
    typedef enum logic [2:0] {
        ACC_IDLE  = 3'h0,
        ACC_DELAY = 3'h1,
        ACC_CONV  = 3'h3,
        ACC_ABORT = 3'h2,
        ACC_OFF   = 3'h6
    } acc_state_t;
endpackage

// ==== core/acc_tad_div.sv ====
// Conversion-clock tick generator.
// Assumes a free running system clock; internal oscillator modelled as ratio.
`timescale 1ns/1ps
module acc_tad_div
    import acc_pkg::*;
#(
    parameter int RC_DIV = 64   // Stand-in ratio for the internal oscillator /64
)(
    input  wire logic clk_in,
    input  wire logic arst_n_in,
    acc_tad_if.div    tad
);
    typedef struct packed {
        logic [7:0] cnt;   // Cycles within a period
        logic       tick;  // Registered tick
    } acc_div_st_t;
    acc_div_st_t s_q, s_d;
    logic [7:0] lim;       // Period minus one

    // Period per select code
    always_comb
    begin
        case (tad.sel)
            3'h1:    lim = 8'h07;
            3'h5:    lim = 8'h0F;
            3'h2:    lim = 8'h1F;
            3'h6:    lim = 8'h3F;
            3'h3,
            3'h7:    lim = 8'(RC_DIV - 1);
            default: lim = 8'h07;             // Reserved codes run as /8
        endcase
    end

    // Count while allowed
    always_comb
    begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!tad.run)
            s_d.cnt = 8'h00;
        else if (s_q.cnt >= lim)
        begin
            s_d.cnt  = 8'h00;
            s_d.tick = 1'b1;
        end
        else
            s_d.cnt = s_q.cnt + 8'h01;
    end

    always_ff @(posedge clk_in or negedge arst_n_in)
        if (!arst_n_in)
            s_q <= '0;
        else
            s_q <= s_d;

    assign tad.tick = s_q.tick;
endmodule // acc_tad_div

// ==== core/acc_tad_if.sv ====
// Divider control bundle between sequencer and divider.
// Assumes both ends share the system clock.
`timescale 1ns/1ps
interface acc_tad_if;
    logic       run;      // Divider may count
    logic [2:0] sel;      // Clock select field
    logic       tick;     // One conversion-clock period elapsed
    modport ctrl (output run, output sel, input tick);
    modport div  (input run, input sel, output tick);
endinterface

// ==== verif/tb_adc_conversion_control.sv ====
// Self-checking bench for the converter sequencing block.
// Assumes acc_pkg and acc_ctrl compiled first; drives the AXI4-Lite port directly.
`timescale 1ns/1ps
module tb_adc_conversion_control;
    import acc_pkg::*;
    // One ordinary conversion case
    typedef struct {logic [2:0] cks; logic [4:0] chs; logic [9:0] smp; int div;} acc_row_t;
    localparam int RC = 4;                 // Short internal oscillator ratio
    logic        clk      = 1'b0;
    logic        arst_n   = 1'b0;
    logic [7:0]  awaddr   = 8'h00;
    logic        awvalid  = 1'b0;
    logic [31:0] wdata    = 32'h0;
    logic        wvalid   = 1'b0;
    logic        bready   = 1'b0;
    logic [7:0]  araddr   = 8'h00;
    logic        arvalid  = 1'b0;
    logic        rready   = 1'b0;
    logic        sleep    = 1'b0;
    logic [9:0]  smp      = 10'h000;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, d;
    logic        pwr, chvalid, acq, flag, wake;
    logic [4:0]  chan;
    int          miscompares = 0;
    int          comparisons = 0;
    int          cyc         = 0;
    int          t0, n;
    // Dividers 8/16/32/64, internal source twice, reserved code acts as /8
    acc_row_t rows [7] = '{'{3'h1, 5'h00, 10'h3FF, 8}, '{3'h5, 5'h0C, 10'h200, 16},
        '{3'h2, 5'h0D, 10'h0AA, 32}, '{3'h6, 5'h10, 10'h001, 64}, '{3'h3, 5'h17, 10'h2C3, RC},
        '{3'h7, 5'h18, 10'h0F0, RC}, '{3'h0, 5'h1F, 10'h155, 8}};

    acc_ctrl #(.RC_DIV(RC)) i_acc_ctrl (.CLOCK_IN(clk), .ARST_N_IN(arst_n),
        .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
        .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wvalid),
        .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
        .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
        .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
        .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .SLEEP_IN(sleep), .SAMPLE_IN(smp),
        .CONVERTER_POWER_OUT(pwr), .CHANNEL_OUT(chan), .CHANNEL_VALID_OUT(chvalid),
        .ACQUIRE_OUT(acq), .CONV_DONE_FLAG_OUT(flag), .WAKE_OUT(wake));

    // 100 MHz clock
    always #5 clk = ~clk;

    // Cycle count and hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            miscompares++;
            $display("unexpected timeout at cycle %0d", cyc);
            tally_and_finish();
        end
    end

    // Verdict and end of run
    task automatic tally_and_finish();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Four-state compare
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        logic aw_t;
        logic w_t;
        aw_t = 1'b0;
        w_t = 1'b0;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= v;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_t && w_t))
        begin
            @(posedge clk);
            if (!aw_t && awready === 1'b1)
            begin
                aw_t = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_t && wready === 1'b1)
            begin
                w_t = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        @(posedge clk);   // Idle edge: a following call never re-raises bready in this step
    endtask

    // Read: address held until taken, data taken at the response edge
    task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        v = rdata;
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        @(posedge clk);   // Idle edge: a following call never re-raises rready in this step
    endtask

    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        // Ordinary conversions, enable written before start
        foreach (rows[i])
        begin
            smp <= rows[i].smp;
            wr(ACC_OFS_CLKSEL, {25'h0, rows[i].cks, 4'h0}, 2'h0);
            rd(ACC_OFS_CLKSEL, d, 2'h0);
            chk("clksel", {25'h0, rows[i].cks, 4'h0}, d);
            wr(ACC_OFS_CTRL, {25'h0, rows[i].chs, 2'h1}, 2'h0);
            chk("power", 32'h1, {31'h0, pwr});
            chk("channel", {27'h0, rows[i].chs}, {27'h0, chan});
            chk("chvalid", {31'h0, rows[i].chs <= 5'h0C || (rows[i].chs >= 5'h10 && rows[i].chs <= 5'h17)},
                {31'h0, chvalid});
            wr(ACC_OFS_CTRL, {25'h0, rows[i].chs, 2'h3}, 2'h0);
            t0 = cyc;
            rd(ACC_OFS_CTRL, d, 2'h0);
            chk("busy", {25'h0, rows[i].chs, 2'h3}, d);
            while (flag !== 1'b1) @(posedge clk);
            chk("duration", 32'h1, {31'h0, (cyc - t0) >= 10 * rows[i].div
                && (cyc - t0) <= 12 * rows[i].div + 8});
            rd(ACC_OFS_CTRL, d, 2'h0);
            chk("go_clear", {25'h0, rows[i].chs, 2'h1}, d);
            rd(ACC_OFS_RESH, d, 2'h0);
            chk("res_hi", {30'h0, rows[i].smp[9:8]}, d);
            rd(ACC_OFS_RESL, d, 2'h0);
            chk("res_lo", {24'h0, rows[i].smp[7:0]}, d);
            rd(ACC_OFS_IRQ, d, 2'h0);
            chk("flag", 32'h1, d);
            wr(ACC_OFS_IRQ, 32'h1, 2'h0);
            rd(ACC_OFS_IRQ, d, 2'h0);
            chk("flag_clr", 32'h0, d);
            wr(ACC_OFS_CTRL, 32'h0, 2'h0);
            chk("power_off", 32'h0, {31'h0, pwr});
        end
        // Unimplemented bits, start in the enabling write
        wr(ACC_OFS_CLKSEL, 32'hFF, 2'h0);
        rd(ACC_OFS_CLKSEL, d, 2'h0);
        chk("clksel_mask", 32'h70, d);
        wr(ACC_OFS_CTRL, 32'h2, 2'h0);
        rd(ACC_OFS_CTRL, d, 2'h0);
        chk("go_disabled", 32'h0, d);
        wr(ACC_OFS_CTRL, 32'hFF, 2'h0);
        rd(ACC_OFS_CTRL, d, 2'h0);
        chk("ctrl_mask", 32'h7D, d);
        // Unmapped place
        wr(8'h14, 32'h0, 2'h2);
        rd(8'h14, d, 2'h2);
        chk("unmapped", 32'h0, d);
        // Abort mid conversion keeps the old result
        wr(ACC_OFS_CLKSEL, 32'h10, 2'h0);
        wr(ACC_OFS_CTRL, 32'h1, 2'h0);
        wr(ACC_OFS_CTRL, 32'h3, 2'h0);
        smp <= 10'h0F0;
        repeat (20) @(posedge clk);
        wr(ACC_OFS_CTRL, 32'h1, 2'h0);
        chk("acq_hold", 32'h0, {31'h0, acq});
        for (n = 0; n < 100 && acq !== 1'b1; n++) @(posedge clk);
        chk("acq_restart", 32'h1, {31'h0, n >= 2 * 8 - 4 && n <= 3 * 8 + 8});
        repeat (120) @(posedge clk);
        rd(ACC_OFS_RESL, d, 2'h0);
        chk("res_kept", 32'h55, d);
        rd(ACC_OFS_IRQ, d, 2'h0);
        chk("no_flag", 32'h0, d);
        // Sleep with a system divider aborts
        wr(ACC_OFS_CTRL, 32'h3, 2'h0);
        repeat (10) @(posedge clk);
        sleep <= 1'b1;
        repeat (20) @(posedge clk);
        chk("sleep_pwr", 32'h0, {31'h0, pwr});
        rd(ACC_OFS_CTRL, d, 2'h0);
        chk("sleep_abort", 32'h1, d);
        sleep <= 1'b0;
        // Internal source with irq enabled wakes the core
        wr(ACC_OFS_CLKSEL, 32'h30, 2'h0);
        wr(ACC_OFS_IRQ, 32'h2, 2'h0);
        wr(ACC_OFS_CTRL, 32'h3, 2'h0);
        sleep <= 1'b1;
        for (n = 0; n < 300 && wake !== 1'b1; n++) @(posedge clk);
        chk("wake", 32'h1, {31'h0, n < 300});
        rd(ACC_OFS_IRQ, d, 2'h0);
        chk("sleep_done", 32'h3, d);
        sleep <= 1'b0;
        wr(ACC_OFS_IRQ, 32'h1, 2'h0);
        // Internal source without irq powers down after completion
        wr(ACC_OFS_CTRL, 32'h3, 2'h0);
        sleep <= 1'b1;
        for (n = 0; n < 300 && flag !== 1'b1; n++) @(posedge clk);
        repeat (4) @(posedge clk);
        chk("rc_pwr", 32'h0, {31'h0, pwr});
        rd(ACC_OFS_CTRL, d, 2'h0);
        chk("rc_en_kept", 32'h1, d);
        sleep <= 1'b0;
        // Reset in mid conversion; wake must clear the synchroniser first
        repeat (4) @(posedge clk);
        wr(ACC_OFS_CTRL, 32'h3, 2'h0);
        rd(ACC_OFS_CTRL, d, 2'h0);
        chk("rst_busy", 32'h3, d);
        repeat (5) @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        chk("rst_pwr", 32'h0, {31'h0, pwr});
        rd(ACC_OFS_CTRL, d, 2'h0);
        chk("rst_ctrl", {24'h0, ACC_RST_CTRL}, d);
        rd(ACC_OFS_CLKSEL, d, 2'h0);
        chk("rst_clksel", {24'h0, ACC_RST_CLKSEL}, d);
        rd(ACC_OFS_IRQ, d, 2'h0);
        chk("rst_irq", 32'h0, d);
        tally_and_finish();
    end
endmodule // tb_adc_conversion_control
